// >>> usbcb_defines.svh
// Bit positions and reset values of the USB control bits.
// Included by the package and the design modules; holds definitions only.
`ifndef USBCB_DEFINES_SVH
`define USBCB_DEFINES_SVH
`define USBCB_BIT_FRST 4
`define USBCB_BIT_RWAKE 5
`define USBCB_BIT_IRCODEC 6
`define USBCB_RST_FRST 1'h1
`define USBCB_RST_RWAKE 1'h0
`define USBCB_RST_IRCODEC 1'h0
`define USBCB_RST_SYNC 1'h0
`define USBCB_RST_MCU 1'h0
`define USBCB_RST_PULSE 1'h0
`define USBCB_RD_ZERO 8'h00
`define USBCB_CTRL_RST 8'h10
`endif

// >>> usbcb_pkg.sv
// Types shared by the control bit block.
// Assumes usbcb_defines.svh is on the include path.
`include "usbcb_defines.svh"
package usbcb_pkg;
  // Firmware write to the control byte
  typedef struct packed {
    logic we;
    logic [7:0] data;
  } usbcb_wr_t;
  // Wake pulse states
  typedef enum logic [1:0] {
    WK_IDLE = 2'h1,
    WK_PULSE = 2'h2
  } usbcb_wk_t;
endpackage : usbcb_pkg

// >>> usbcb_wake.sv
// Remote wake request: one-cycle pulse, self-clearing request bit.
// Assumes write strobe is synchronous to CLOCK.
`timescale 1ns/10ps
`include "usbcb_defines.svh"
module usbcb_wake (
  input wire logic clk, // Controller clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic set_req, // Firmware wrote 1 to wake bit
  output logic pulse_r, // Wake pulse
  output logic req_r // Request bit readback
);
  usbcb_pkg::usbcb_wk_t state_r;
  usbcb_pkg::usbcb_wk_t state_nxt;
  logic pulse_nxt;
  logic req_nxt;

  // Next state of the wake sequencer
  always_comb
  begin
    state_nxt = state_r;
    pulse_nxt = 1'h0;
    req_nxt = 1'h0;
    case (state_r)
      usbcb_pkg::WK_IDLE:
      begin
        if (set_req) // [RULE2] [RULE4]
        begin
          state_nxt = usbcb_pkg::WK_PULSE;
          pulse_nxt = 1'h1;
          req_nxt = 1'h1;
        end
      end
      usbcb_pkg::WK_PULSE:
      begin
        state_nxt = usbcb_pkg::WK_IDLE; // [RULE3] [RULE6]
      end
      default:
      begin
        state_nxt = usbcb_pkg::WK_IDLE;
      end
    endcase
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= usbcb_pkg::WK_IDLE;
      pulse_r <= `USBCB_RST_PULSE;
      req_r <= `USBCB_RST_RWAKE;
    end
    else
    begin
      state_r <= state_nxt;
      pulse_r <= pulse_nxt;
      req_r <= req_nxt;
    end
  end
endmodule : usbcb_wake

// >>> usbcb_top.sv
// USB control bits: function reset link, remote wake, infrared select.
// Assumes firmware writes arrive synchronous to CLOCK; FUNC_RESET is a pin.
//
// How it works
// [RULE1] Bit 4 resets to 1; when set, USB function reset resets controller.
// [RULE2] Writing 1 to bit 5 yields one remote-wakeup pulse; the code drops a 1 written in the pulse cycle.
// [RULE3] Bit 5 clears itself after the wake request is issued.
// [RULE4] Writing 0 to bit 5 does nothing.
// [RULE5] Bit 6 resets to 0; 1 selects infrared codec, 0 plain serial.
// [RULE6] Wake pulse lasts one cycle; bit reads 0 the next cycle.
`timescale 1ns/10ps
`include "usbcb_defines.svh"
module usbcb_top (
  input wire logic CLOCK, // 10 MHz clock
  input wire logic RST_N, // Synchronous reset, active low
  input wire usbcb_pkg::usbcb_wr_t WR, // Firmware byte write
  input wire logic FUNC_RESET, // USB function reset, from pin
  output logic [7:0] RDATA, // Control byte readback
  output logic MCU_RESET, // Controller reset request
  output logic WAKE_PULSE, // Remote wakeup pulse
  output logic IR_SEL, // Infrared codec active
  output logic UART_SEL // Plain serial active
);
  // Link bit and its next value
  logic frst_r;
  logic frst_nxt;
  // Infrared codec bit and its next value
  logic ircodec_r;
  logic ircodec_nxt;
  // Synchroniser stages for the function reset pin
  logic fr_s1_r;
  logic fr_s1_nxt;
  logic fr_s2_r;
  logic fr_s2_nxt;
  // Next values of the registered outputs
  logic mcu_rst_nxt;
  logic [7:0] rdata_nxt;
  logic ir_sel_nxt;
  logic uart_sel_nxt;
  // Wake decode
  logic wake_set;
  logic wake_req;
  logic wake_take;

  // New value of a firmware bit on a write, else the held value
  function automatic logic wr_field(
    input usbcb_pkg::usbcb_wr_t wr, // Firmware write
    input int unsigned pos, // Bit position
    input logic cur // Held value
  );
    wr_field = cur;
    if (wr.we)
    begin
      wr_field = wr.data[pos];
    end
  endfunction : wr_field

  // Set when a write carries a 1 at the given position
  function automatic logic wr_one(
    input usbcb_pkg::usbcb_wr_t wr, // Firmware write
    input int unsigned pos // Bit position
  );
    wr_one = wr.we & wr.data[pos];
  endfunction : wr_one

  // Readback byte from the three bits; the rest read 0
  function automatic logic [7:0] pack_ctrl(
    input logic link, // Link bit
    input logic wake, // Wake request bit
    input logic ircodec // Infrared codec bit
  );
    pack_ctrl = `USBCB_RD_ZERO;
    pack_ctrl[`USBCB_BIT_FRST] = link;
    pack_ctrl[`USBCB_BIT_RWAKE] = wake;
    pack_ctrl[`USBCB_BIT_IRCODEC] = ircodec;
  endfunction : pack_ctrl

  // Wake decode; a 0 at the wake bit is no request at all
  assign wake_set = wr_one(WR, `USBCB_BIT_RWAKE); // [RULE2] [RULE4]
  // Dropped while a pulse runs, so readback matches the pulse
  assign wake_take = wake_set & ~wake_req; // [RULE6]

  // Wake pulse sequencer
  usbcb_wake u_wake (
    .clk(CLOCK),
    .rst_n(RST_N),
    .set_req(wake_set),
    .pulse_r(WAKE_PULSE),
    .req_r(wake_req)
  );

  // Link bit: firmware writes it, reset sets it
  always_comb
  begin
    frst_nxt = wr_field(WR, `USBCB_BIT_FRST, frst_r); // [RULE1]
  end

  // Link bit register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      frst_r <= `USBCB_RST_FRST; // [RULE1]
    end
    else
    begin
      frst_r <= frst_nxt;
    end
  end

  // Infrared codec bit: firmware writes it, reset clears it
  always_comb
  begin
    ircodec_nxt = wr_field(WR, `USBCB_BIT_IRCODEC, ircodec_r); // [RULE5]
  end

  // Infrared codec bit register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      ircodec_r <= `USBCB_RST_IRCODEC; // [RULE5]
    end
    else
    begin
      ircodec_r <= ircodec_nxt;
    end
  end

  // Two stages: the pin is not timed to CLOCK
  always_comb
  begin
    fr_s1_nxt = FUNC_RESET;
    fr_s2_nxt = fr_s1_r;
  end

  // Synchroniser registers
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      fr_s1_r <= `USBCB_RST_SYNC;
      fr_s2_r <= `USBCB_RST_SYNC;
    end
    else
    begin
      fr_s1_r <= fr_s1_nxt;
      fr_s2_r <= fr_s2_nxt;
    end
  end

  // Controller reset: synced function reset gated by the link bit
  always_comb
  begin
    mcu_rst_nxt = fr_s2_r & frst_r; // [RULE1]
  end

  // Controller reset output register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      MCU_RESET <= `USBCB_RST_MCU;
    end
    else
    begin
      MCU_RESET <= mcu_rst_nxt;
    end
  end

  // Readback byte; wake bit shows 1 only in the pulse cycle
  always_comb
  begin
    rdata_nxt = pack_ctrl(frst_nxt, wake_take, ircodec_nxt); // [RULE6]
  end

  // Readback register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      RDATA <= `USBCB_CTRL_RST;
    end
    else
    begin
      RDATA <= rdata_nxt;
    end
  end

  // Infrared path select follows the codec bit
  always_comb
  begin
    ir_sel_nxt = ircodec_nxt; // [RULE5]
  end

  // Infrared select register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      IR_SEL <= `USBCB_RST_IRCODEC;
    end
    else
    begin
      IR_SEL <= ir_sel_nxt;
    end
  end

  // Plain serial select is the inverse, so one path is always chosen
  always_comb
  begin
    uart_sel_nxt = ~ircodec_nxt; // [RULE5]
  end

  // Plain serial select register
  always_ff @(posedge CLOCK)
  begin
    if (!RST_N)
    begin
      UART_SEL <= ~`USBCB_RST_IRCODEC;
    end
    else
    begin
      UART_SEL <= uart_sel_nxt;
    end
  end
endmodule : usbcb_top

// >>> usbcb_sva.sv
// Checker of the control bit outputs.
// Assumes a bind to usbcb_top.
`timescale 1ns/10ps
module usbcb_sva (
  input wire logic CLOCK, // Clock
  input wire logic RST_N, // Reset
  input wire usbcb_pkg::usbcb_wr_t WR, // Write
  input wire logic FUNC_RESET, // Pin
  input wire logic [7:0] RDATA, // Readback
  input wire logic MCU_RESET, // Reset out
  input wire logic WAKE_PULSE, // Pulse
  input wire logic IR_SEL, // Infrared
  input wire logic UART_SEL // Serial
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  // Output relations
  a_link_cut: assert property (MCU_RESET |-> $past(RDATA[4]))
    else $error("reset out with link off");
  a_wake_once: assert property (WR.we && WR.data[5] && !WAKE_PULSE
    |=> WAKE_PULSE ##1 !WAKE_PULSE) else $error("wake pulse wrong");
  a_wake_clear: assert property (RDATA[5] |=> !RDATA[5])
    else $error("wake bit stuck");
  a_wake_cause: assert property (WAKE_PULSE |->
    $past(WR.we && WR.data[5])) else $error("pulse without wake write");
  a_mode_excl: assert property (IR_SEL != UART_SEL)
    else $error("mode outputs clash");
  a_mode_hold: assert property (!WR.we |=> $stable(RDATA[6]))
    else $error("mode bit changed alone");
  a_wake_read: assert property (RDATA[5] == WAKE_PULSE)
    else $error("wake readback differs");
  // Main scenarios
  c_wake: cover property (WAKE_PULSE);
  c_reset: cover property (MCU_RESET);
  c_ir: cover property (IR_SEL);
endmodule : usbcb_sva

// >>> usb_control_bits_tb.sv
// Random writes against an integer model.
// Assumes usbcb_top and usbcb_sva compiled first.
`timescale 1ns/10ps
module usb_control_bits_tb;
  logic CLOCK = 0, RST_N = 0, FUNC_RESET = 0;
  usbcb_pkg::usbcb_wr_t WR = '0;
  logic [7:0] RDATA, r = 8'h51;
  logic MCU_RESET, WAKE_PULSE, IR_SEL, UART_SEL;
  int n_errors = 0, n_checks = 0, cyc = 0;
  int lk = 1, ir = 0, wk = 0, mc = 0, s1 = 0, s2 = 0;
  wire [11:0] got = {RDATA, MCU_RESET, WAKE_PULSE, IR_SEL, UART_SEL};
  logic [11:0] want;
  usbcb_top dut (.CLOCK(CLOCK), .RST_N(RST_N), .WR(WR),
    .FUNC_RESET(FUNC_RESET), .RDATA(RDATA), .MCU_RESET(MCU_RESET),
    .WAKE_PULSE(WAKE_PULSE), .IR_SEL(IR_SEL), .UART_SEL(UART_SEL));
  always #50 CLOCK = ~CLOCK;
  function automatic logic [7:0] lfsr(input logic [7:0] x);
    lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction : lfsr
  task test_done;
    if (n_errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  // Model update and random stimulus
  always @(posedge CLOCK)
  begin
    cyc <= cyc + 1;
    if (!RST_N)
    begin
      lk = 1; ir = 0; wk = 0; mc = 0; s1 = 0; s2 = 0;
    end
    else
    begin
      mc = s2 & lk;
      s2 = s1;
      s1 = FUNC_RESET;
      wk = WR.we & WR.data[5] & !wk;
      if (WR.we)
      begin
        lk = WR.data[4];
        ir = WR.data[6];
      end
    end
    r = lfsr(r);
    RST_N <= cyc >= 11 && cyc != 300;
    WR <= {r[0] | r[3], r};
    FUNC_RESET <= cyc % 40 > 20;
  end
  // Compare at every cycle
  always @(negedge CLOCK)
    if (cyc > 0)
    begin
      want = {1'b0, ir[0], wk[0], lk[0], 4'h0, mc[0], wk[0], ir[0], !ir[0]};
      n_checks++;
      if (got !== want)
      begin
        n_errors++;
        $display("mismatch t=%0t got %h exp %h", $time, got, want);
      end
    end
  initial
  begin
    repeat (600) @(posedge CLOCK);
    test_done;
  end
endmodule : usb_control_bits_tb
bind usbcb_top usbcb_sva u_sva (.CLOCK(CLOCK), .RST_N(RST_N), .WR(WR),
  .FUNC_RESET(FUNC_RESET), .RDATA(RDATA), .MCU_RESET(MCU_RESET),
  .WAKE_PULSE(WAKE_PULSE), .IR_SEL(IR_SEL), .UART_SEL(UART_SEL));
